// *** hw/tpc_top.sv ***
// Test-pattern checker, error injector and error counter with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
module tpc_top #(
    parameter int ADDR_W = 8,
    parameter int LOCK_RUN = 4
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire tpc_pkg::tpc_rx_slot_t rx_slot,
    input wire tpc_pkg::tpc_tx_slot_t tx_gen,
    output var tpc_pkg::tpc_tx_slot_t tx_out,
    output logic chk_locked
);
    localparam logic [4:0] LOCK_LAST = 5'(LOCK_RUN - 1);

    function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
        return a[tpc_pkg::IDX_W+1:2];
    endfunction

    function automatic logic mapped(input logic [5:0] i);
        case (i)
            tpc_pkg::IDX_INT_FLAGS,
            tpc_pkg::IDX_TEST_CMD,
            tpc_pkg::IDX_STYLE,
            tpc_pkg::IDX_CHK_HWY,
            tpc_pkg::IDX_UPPER,
            tpc_pkg::IDX_LOWER,
            tpc_pkg::IDX_USER,
            tpc_pkg::IDX_INJECT,
            tpc_pkg::IDX_CNT_LO,
            tpc_pkg::IDX_CNT_HI: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Feedback taps {p, q}; zero marks a fixed-byte style
    function automatic logic [9:0] style_taps(input logic [3:0] st);
        case (st)
            tpc_pkg::STY_PRBS7: return {5'h07, 5'h06};
            tpc_pkg::STY_PRBS9: return {5'h09, 5'h05};
            tpc_pkg::STY_PRBS11: return {5'h0B, 5'h09};
            tpc_pkg::STY_PRBS15: return {5'h0F, 5'h0E};
            tpc_pkg::STY_PRBS20: return {5'h14, 5'h11};
            tpc_pkg::STY_PRBS23: return {5'h17, 5'h12};
            tpc_pkg::STY_QRSS: return {5'h14, 5'h03};
            tpc_pkg::STY_PRBS29: return {5'h1D, 5'h1B};
            tpc_pkg::STY_PRBS31: return {5'h1F, 5'h1C};
            default: return 10'h000;
        endcase
    endfunction

    function automatic logic [7:0] style_byte(input logic [3:0] st, input logic [7:0] usr);
        case (st)
            tpc_pkg::STY_USER: return usr;
            tpc_pkg::STY_ONES: return tpc_pkg::PAT_ONES;
            tpc_pkg::STY_ALT: return tpc_pkg::PAT_ALT;
            tpc_pkg::STY_ALT_INV: return tpc_pkg::PAT_ALT_INV;
            tpc_pkg::STY_NIBBLE: return tpc_pkg::PAT_NIBBLE;
            default: return tpc_pkg::PAT_ZERO;
        endcase
    endfunction

    // Eight recurrence steps, first bit lands in bit 7 of the byte
    function automatic logic [31:0] prbs_step(input logic [31:0] s, input logic [9:0] t);
        logic [31:0] r;
        r = s;
        for (int i = 0; i < 8; i++) begin
            r = {r[30:0], r[t[9:5] - 5'h01] ^ r[t[4:0] - 5'h01]};
        end
        return r;
    endfunction

    function automatic logic [7:0] slot_limit(input logic [1:0] rate);
        logic [1:0] r;
        r = (rate > tpc_pkg::RATE_MAX) ? tpc_pkg::RATE_MAX : rate;
        return tpc_pkg::SLOTS_MIN << r;
    endfunction

    logic [7:0] test_cmd_ff;
    logic [7:0] style_ff;
    logic [7:0] hwy_ff;
    logic [7:0] upper_ff;
    logic [7:0] lower_ff;
    logic [7:0] user_ff;
    logic [7:0] inj_left_ff;
    logic [7:0] flags_ff;
    logic [15:0] cnt_ff;
    logic [7:0] hi_latch_ff;
    logic lo_read_ff;
    logic start_d_ff;
    logic arm_ff;
    logic locked_ff;
    logic [4:0] run_ff;
    logic [31:0] chk_state_ff;
    logic aw_full_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic w_full_ff;
    logic [7:0] w_data_ff;
    logic w_lane0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [7:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [7:0] rd_val;

    // Write path: address and data are caught apart, then applied together
    logic wr_fire;
    logic [5:0] wr_idx;
    logic wr_en;
    logic rd_fire;
    logic [5:0] rd_idx;
    assign s_axi_awready = clk_en & ~aw_full_ff & ~bvalid_ff;
    assign s_axi_wready = clk_en & ~w_full_ff & ~bvalid_ff;
    assign wr_fire = aw_full_ff & w_full_ff & ~bvalid_ff;
    assign wr_idx = word_idx(aw_addr_ff);
    assign wr_en = wr_fire & w_lane0_ff & mapped(wr_idx);
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = clk_en & ~rvalid_ff;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign rd_idx = word_idx(s_axi_araddr);
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = 32'(rdata_ff);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            aw_full_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_full_ff <= 1'b0;
            w_data_ff <= tpc_pkg::REG_RST;
            w_lane0_ff <= 1'b0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_ff <= 1'b1;
                w_data_ff <= s_axi_wdata[7:0];
                w_lane0_ff <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_full_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= tpc_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= mapped(wr_idx) ? tpc_pkg::RESP_OKAY : tpc_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Reads return the value before any clear-on-read takes effect
    always_comb begin
        rd_val = tpc_pkg::REG_RST;
        case (rd_idx)
            tpc_pkg::IDX_INT_FLAGS: rd_val = flags_ff;
            tpc_pkg::IDX_TEST_CMD: rd_val = test_cmd_ff;
            tpc_pkg::IDX_STYLE: rd_val = style_ff;
            tpc_pkg::IDX_CHK_HWY: rd_val = 8'(hwy_ff[tpc_pkg::HWY_W-1:0]);
            tpc_pkg::IDX_UPPER: rd_val = upper_ff;
            tpc_pkg::IDX_LOWER: rd_val = lower_ff;
            tpc_pkg::IDX_USER: rd_val = user_ff;
            tpc_pkg::IDX_INJECT: rd_val = inj_left_ff;
            tpc_pkg::IDX_CNT_LO: rd_val = cnt_ff[7:0];
            tpc_pkg::IDX_CNT_HI: rd_val = lo_read_ff ? hi_latch_ff : cnt_ff[15:8];
            default: rd_val = tpc_pkg::REG_RST;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= tpc_pkg::REG_RST;
            rresp_ff <= tpc_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (rd_fire) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_val;
                rresp_ff <= mapped(rd_idx) ? tpc_pkg::RESP_OKAY : tpc_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Configuration registers
    logic inj_fin;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            style_ff <= tpc_pkg::REG_RST;
            hwy_ff <= tpc_pkg::REG_RST;
            upper_ff <= tpc_pkg::REG_RST;
            lower_ff <= tpc_pkg::REG_RST;
            user_ff <= tpc_pkg::REG_RST;
        end else if (clk_en && wr_en) begin
            case (wr_idx)
                tpc_pkg::IDX_STYLE: style_ff <= w_data_ff;
                tpc_pkg::IDX_CHK_HWY: hwy_ff <= w_data_ff;
                tpc_pkg::IDX_UPPER: upper_ff <= w_data_ff;
                tpc_pkg::IDX_LOWER: lower_ff <= w_data_ff;
                tpc_pkg::IDX_USER: user_ff <= w_data_ff;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            test_cmd_ff <= tpc_pkg::REG_RST;
        end else if (clk_en && inj_fin) begin
            test_cmd_ff <= tpc_pkg::REG_RST;
        end else if (clk_en && wr_en && wr_idx == tpc_pkg::IDX_TEST_CMD) begin
            test_cmd_ff <= w_data_ff;
        end
    end

    // Checker slot qualification
    logic [3:0] checker_style_code;
    logic [1:0] checker_rate_select;
    logic checker_start_bit;
    logic chk_on;
    logic hwy_ok;
    logic in_rng;
    logic hit;
    logic [9:0] taps;
    logic [31:0] pred_state;
    logic [7:0] expected;
    logic match;
    logic pd_evt;
    logic err_evt;
    assign checker_style_code = style_ff[tpc_pkg::STY_CHK_LSB +: 4];
    assign checker_rate_select = test_cmd_ff[tpc_pkg::CMD_RATE_LSB +: 2];
    assign checker_start_bit = test_cmd_ff[tpc_pkg::CMD_START];
    assign chk_on = checker_start_bit & (checker_style_code != tpc_pkg::STY_NONE);
    assign hwy_ok = rx_slot.vld & (rx_slot.hwy == hwy_ff[tpc_pkg::HWY_W-1:0]);
    assign in_rng = ({1'b0, rx_slot.slot} >= lower_ff) & ({1'b0, rx_slot.slot} <= upper_ff)
        & ({1'b0, rx_slot.slot} < slot_limit(checker_rate_select));
    assign hit = chk_on & hwy_ok & in_rng;
    assign taps = style_taps(checker_style_code);
    assign pred_state = prbs_step(chk_state_ff, taps);
    assign expected = (taps == 10'h000) ? style_byte(checker_style_code, user_ff)
        : pred_state[7:0];
    assign match = expected == rx_slot.data;
    assign pd_evt = hit & ~locked_ff & match & (run_ff == LOCK_LAST) & arm_ff;
    assign err_evt = hit & locked_ff & ~match;
    assign chk_locked = locked_ff;

    // Before lock the sequence register follows the line; after it, the prediction,
    // so a single line error costs one count and not a burst
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            locked_ff <= 1'b0;
            run_ff <= '0;
            chk_state_ff <= '0;
        end else if (clk_en) begin
            if (!chk_on) begin
                locked_ff <= 1'b0;
                run_ff <= '0;
            end else if (hit && !locked_ff) begin
                chk_state_ff <= {chk_state_ff[23:0], rx_slot.data};
                run_ff <= match ? run_ff + 5'h01 : '0;
                locked_ff <= match & (run_ff == LOCK_LAST);
            end else if (hit) begin
                chk_state_ff <= pred_state;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            start_d_ff <= 1'b0;
            arm_ff <= 1'b0;
        end else if (clk_en) begin
            start_d_ff <= checker_start_bit;
            if (checker_start_bit && !start_d_ff) begin
                arm_ff <= 1'b1;
            end else if (pd_evt || !checker_start_bit) begin
                arm_ff <= 1'b0;
            end
        end
    end

    // Error counter with latch across the two byte reads
    logic lo_rd;
    logic hi_clr;
    assign lo_rd = rd_fire & (rd_idx == tpc_pkg::IDX_CNT_LO);
    assign hi_clr = rd_fire & (rd_idx == tpc_pkg::IDX_CNT_HI) & lo_read_ff;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_ff <= '0;
            hi_latch_ff <= tpc_pkg::REG_RST;
            lo_read_ff <= 1'b0;
        end else if (clk_en) begin
            if (hi_clr) begin
                cnt_ff <= err_evt ? tpc_pkg::CNT_ONE : '0;
            end else if (err_evt && cnt_ff != tpc_pkg::CNT_MAX) begin
                cnt_ff <= cnt_ff + tpc_pkg::CNT_ONE;
            end
            if (lo_rd) begin
                hi_latch_ff <= cnt_ff[15:8];
                lo_read_ff <= 1'b1;
            end else if (hi_clr) begin
                lo_read_ff <= 1'b0;
            end
        end
    end

    // Error injection, one per generated slot
    logic wr_inj;
    logic inj_now;
    assign wr_inj = wr_en & (wr_idx == tpc_pkg::IDX_INJECT);
    assign inj_now = tx_gen.vld & (inj_left_ff != tpc_pkg::REG_RST) & ~wr_inj;
    assign inj_fin = inj_now & (inj_left_ff == tpc_pkg::INJ_MASK);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            inj_left_ff <= tpc_pkg::REG_RST;
            tx_out <= '0;
        end else if (clk_en) begin
            if (wr_inj) begin
                inj_left_ff <= w_data_ff;
            end else if (inj_now) begin
                inj_left_ff <= inj_left_ff - tpc_pkg::INJ_MASK;
            end
            tx_out.vld <= tx_gen.vld;
            tx_out.data <= tx_gen.data ^ (inj_now ? tpc_pkg::INJ_MASK : tpc_pkg::PAT_ZERO);
        end
    end

    // Sticky flags: a new event in the clearing read cycle survives
    logic flg_rd;
    logic [7:0] flg_set;
    assign flg_rd = rd_fire & (rd_idx == tpc_pkg::IDX_INT_FLAGS);
    always_comb begin
        flg_set = tpc_pkg::REG_RST;
        flg_set[tpc_pkg::FLG_INJ_DONE] = inj_fin;
        flg_set[tpc_pkg::FLG_ERR_DET] = err_evt;
        flg_set[tpc_pkg::FLG_PAT_DET] = pd_evt;
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flags_ff <= tpc_pkg::REG_RST;
        end else if (clk_en) begin
            flags_ff <= (flg_rd ? tpc_pkg::REG_RST : flags_ff) | flg_set;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst || !clk_en);

    sequence seq_last_inj;
        tx_gen.vld && inj_left_ff == tpc_pkg::INJ_MASK && !wr_inj;
    endsequence
    sequence seq_done_seen;
        flags_ff[tpc_pkg::FLG_INJ_DONE] && test_cmd_ff == tpc_pkg::REG_RST
            && inj_left_ff == tpc_pkg::REG_RST;
    endsequence

    AST_HWY_ONLY: assert property ($rose(flags_ff[tpc_pkg::FLG_ERR_DET]) |-> $past(hwy_ok))
        else $error("error flag from foreign highway");
    AST_RANGE: assert property (err_evt |-> in_rng && locked_ff)
        else $error("error counted outside slot range");
    AST_PD_ONCE: assert property ($rose(flags_ff[tpc_pkg::FLG_PAT_DET]) |-> !arm_ff)
        else $error("detection left armed");
    AST_PD_CAUSE: assert property ($rose(flags_ff[tpc_pkg::FLG_PAT_DET]) |-> locked_ff)
        else $error("pattern flag without lock");
    AST_PD_RC: assert property (flg_rd && !pd_evt |=> !flags_ff[tpc_pkg::FLG_PAT_DET])
        else $error("pattern flag survived read");
    AST_LOCK_OFF: assert property (!checker_start_bit |=> !locked_ff)
        else $error("lock held without start");
    AST_INJ_LOAD: assert property (wr_inj |=> inj_left_ff == $past(w_data_ff))
        else $error("injection count not loaded");
    AST_INJ_STEP: assert property (!wr_inj && inj_left_ff != tpc_pkg::REG_RST && !tx_gen.vld
        |=> inj_left_ff == $past(inj_left_ff))
        else $error("injection without slot");
    AST_INJ_DONE: assert property (seq_last_inj |=> seq_done_seen ##1 (!inj_now || $past(wr_inj)))
        else $error("done flag or command clear missing");
    AST_ERR_CNT: assert property (err_evt && !hi_clr |=> flags_ff[tpc_pkg::FLG_ERR_DET]
        && (cnt_ff == $past(cnt_ff) + tpc_pkg::CNT_ONE || cnt_ff == tpc_pkg::CNT_MAX))
        else $error("mismatch not counted");
    AST_SAT: assert property (cnt_ff == tpc_pkg::CNT_MAX && !hi_clr
        |=> cnt_ff == tpc_pkg::CNT_MAX)
        else $error("counter wrapped");
    AST_CNT_RST: assert property (hi_clr |=> cnt_ff <= tpc_pkg::CNT_ONE && !lo_read_ff)
        else $error("counter not restarted");
    AST_LATCH: assert property (lo_rd |=> hi_latch_ff == $past(cnt_ff[15:8]))
        else $error("high byte not latched");
endmodule
`default_nettype wire

// *** include/tpc_pkg.sv ***
// Constants and carriers of the test-pattern checker block
`default_nettype none
package tpc_pkg;
    localparam int IDX_W = 6;
    localparam logic [5:0] IDX_INT_FLAGS = 6'h07;
    localparam logic [5:0] IDX_TEST_CMD = 6'h09;
    localparam logic [5:0] IDX_STYLE = 6'h0A;
    localparam logic [5:0] IDX_CHK_HWY = 6'h0B;
    localparam logic [5:0] IDX_UPPER = 6'h0C;
    localparam logic [5:0] IDX_LOWER = 6'h0D;
    localparam logic [5:0] IDX_USER = 6'h0E;
    localparam logic [5:0] IDX_INJECT = 6'h0F;
    localparam logic [5:0] IDX_CNT_LO = 6'h10;
    localparam logic [5:0] IDX_CNT_HI = 6'h11;
    localparam int FLG_INJ_DONE = 0;
    localparam int FLG_ERR_DET = 3;
    localparam int FLG_PAT_DET = 5;
    localparam int CMD_START = 6;
    localparam int CMD_RATE_LSB = 2;
    localparam int STY_CHK_LSB = 0;
    localparam int HWY_W = 5;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [7:0] SLOTS_MIN = 8'h20;
    localparam logic [7:0] INJ_MASK = 8'h01;
    localparam logic [1:0] RATE_MAX = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] STY_USER = 4'h0;
    localparam logic [3:0] STY_ZERO = 4'h1;
    localparam logic [3:0] STY_ONES = 4'h2;
    localparam logic [3:0] STY_ALT = 4'h3;
    localparam logic [3:0] STY_PRBS7 = 4'h4;
    localparam logic [3:0] STY_PRBS9 = 4'h5;
    localparam logic [3:0] STY_PRBS11 = 4'h6;
    localparam logic [3:0] STY_PRBS15 = 4'h7;
    localparam logic [3:0] STY_PRBS20 = 4'h8;
    localparam logic [3:0] STY_PRBS23 = 4'h9;
    localparam logic [3:0] STY_QRSS = 4'hA;
    localparam logic [3:0] STY_PRBS29 = 4'hB;
    localparam logic [3:0] STY_PRBS31 = 4'hC;
    localparam logic [3:0] STY_ALT_INV = 4'hD;
    localparam logic [3:0] STY_NIBBLE = 4'hE;
    localparam logic [3:0] STY_NONE = 4'hF;
    localparam logic [7:0] PAT_ZERO = 8'h00;
    localparam logic [7:0] PAT_ONES = 8'hFF;
    localparam logic [7:0] PAT_ALT = 8'h55;
    localparam logic [7:0] PAT_ALT_INV = 8'hAA;
    localparam logic [7:0] PAT_NIBBLE = 8'hF0;
    typedef struct packed {
        logic vld;
        logic [4:0] hwy;
        logic [6:0] slot;
        logic [7:0] data;
    } tpc_rx_slot_t;
    typedef struct packed {
        logic vld;
        logic [7:0] data;
    } tpc_tx_slot_t;
endpackage
`default_nettype wire

// *** tb/tpc_rx_src.sv ***
// Receive highway source feeding the checker one byte per cycle
`timescale 1ns/100ps
`default_nettype none
module tpc_rx_src (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] pat,
    input wire logic err_req,
    output var tpc_pkg::tpc_rx_slot_t rx_slot
);
    logic ph_ff;
    logic [6:0] slot_ff;
    logic [3:0] pend_ff;
    logic hit;
    assign hit = !ph_ff && slot_ff == 7'h05 && pend_ff != 4'h0;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ph_ff <= 1'b0;
            slot_ff <= 7'h00;
            pend_ff <= 4'h0;
            rx_slot <= '0;
        end else begin
            ph_ff <= !ph_ff;
            if (ph_ff) begin
                slot_ff <= (slot_ff == 7'h1F) ? 7'h00 : slot_ff + 7'h01;
            end
            pend_ff <= pend_ff + {3'h0, err_req} - {3'h0, hit};
            // odd cycles: foreign highway, wrong data
            rx_slot <= {1'b1, ph_ff ? 5'h04 : 5'h03, slot_ff,
                        ph_ff ? ~pat : (hit ? pat ^ 8'h80 : pat)};
        end
    end
endmodule
`default_nettype wire

// *** tb/tpc_top_bench.sv ***
// Self-checking bench for the test-pattern checker block
`timescale 1ns/100ps
`default_nettype none
module tpc_top_bench;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic err_req = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00, pat = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic awr, wr_rdy, bv, arr, rv, lock;
    logic [1:0] br, rr;
    tpc_pkg::tpc_rx_slot_t rxs;
    tpc_pkg::tpc_tx_slot_t txg = '0, txo;
    int n_errors = 0, cmp_count = 0, cyc = 0, k, n;
    tpc_top #(.ADDR_W(8), .LOCK_RUN(4)) u_tpc_top (
        .ref_clk(ref_clk), .srst(srst), .clk_en(1'b1), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .rx_slot(rxs), .tx_gen(txg), .tx_out(txo), .chk_locked(lock));
    tpc_rx_src u_tpc_rx_src (.ref_clk(ref_clk), .srst(srst), .pat(pat), .err_req(err_req),
        .rx_slot(rxs));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic end_of_test();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Hang guard, far above the fewer than 1500 cycles needed
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    function automatic logic [7:0] exp_tx(input logic [7:0] d, input logic inj);
        return inj ? d ^ tpc_pkg::INJ_MASK : d;
    endfunction
    // Tasks open on an edge so back-to-back calls never reassign in one step
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        @(posedge ref_clk);
        awa <= {i, 2'b00};
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awr) awv <= 1'b0;
            if (wr_rdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        bry <= 1'b0;
        chk({30'h0, br}, {30'h0, tpc_pkg::RESP_OKAY});
    endtask
    task automatic rd(input logic [5:0] i, input logic [7:0] e, input logic [1:0] er);
        @(posedge ref_clk);
        ara <= {i, 2'b00};
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rry <= 1'b0;
        chk(rdat, {24'h0, e});
        chk({30'h0, rr}, {30'h0, er});
    endtask
    initial begin
        k = $urandom(32'h41BC);
        k = $urandom_range(6, 1);
        n = $urandom_range(4, 1);
        pat <= 8'($urandom);
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        rd(tpc_pkg::IDX_INT_FLAGS, 8'h00, tpc_pkg::RESP_OKAY);
        rd(6'h3F, 8'h00, tpc_pkg::RESP_SLVERR);
        for (int s = 0; s < 16; s++) begin
            wr(tpc_pkg::IDX_STYLE, 8'(s));
            rd(tpc_pkg::IDX_STYLE, 8'(s), tpc_pkg::RESP_OKAY);
        end
        wr(tpc_pkg::IDX_CHK_HWY, 8'h03);
        wr(tpc_pkg::IDX_UPPER, 8'h05);
        wr(tpc_pkg::IDX_LOWER, 8'h05);
        wr(tpc_pkg::IDX_USER, pat);
        wr(tpc_pkg::IDX_STYLE, {4'h0, tpc_pkg::STY_USER});
        wr(tpc_pkg::IDX_TEST_CMD, 8'hC0);
        for (int c = 0; c < 800 && lock !== 1'b1; c++) @(posedge ref_clk);
        chk({31'h0, lock}, 32'h1);
        rd(tpc_pkg::IDX_INT_FLAGS, 8'h20, tpc_pkg::RESP_OKAY);
        rd(tpc_pkg::IDX_INT_FLAGS, 8'h00, tpc_pkg::RESP_OKAY);
        repeat (k) begin
            @(posedge ref_clk);
            err_req <= 1'b1;
            @(posedge ref_clk);
            err_req <= 1'b0;
            repeat (70) @(posedge ref_clk);
        end
        rd(tpc_pkg::IDX_INT_FLAGS, 8'h08, tpc_pkg::RESP_OKAY);
        rd(tpc_pkg::IDX_CNT_LO, 8'(k), tpc_pkg::RESP_OKAY);
        rd(tpc_pkg::IDX_CNT_HI, 8'h00, tpc_pkg::RESP_OKAY);
        rd(tpc_pkg::IDX_CNT_LO, 8'h00, tpc_pkg::RESP_OKAY);
        wr(tpc_pkg::IDX_TEST_CMD, 8'h00);
        pat <= tpc_pkg::PAT_ONES;
        wr(tpc_pkg::IDX_STYLE, {4'h0, tpc_pkg::STY_ONES});
        wr(tpc_pkg::IDX_TEST_CMD, 8'hC4);
        for (int c = 0; c < 800 && lock !== 1'b1; c++) @(posedge ref_clk);
        chk({31'h0, lock}, 32'h1);
        rd(tpc_pkg::IDX_INT_FLAGS, 8'h20, tpc_pkg::RESP_OKAY);
        wr(tpc_pkg::IDX_INJECT, 8'(n));
        for (int j = 0; j < n + 2; j++) begin
            txg <= {1'b1, 8'hA5};
            @(posedge ref_clk);
            txg <= '0;
            @(posedge ref_clk);
            chk({23'h0, txo}, {23'h0, 1'b1, exp_tx(8'hA5, j < n)});
        end
        rd(tpc_pkg::IDX_INT_FLAGS, 8'h01, tpc_pkg::RESP_OKAY);
        rd(tpc_pkg::IDX_TEST_CMD, 8'h00, tpc_pkg::RESP_OKAY);
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        rd(tpc_pkg::IDX_STYLE, 8'h00, tpc_pkg::RESP_OKAY);
        end_of_test();
    end
endmodule
`default_nettype wire
